/* File: hw/dftl_pkg.sv */
package dftl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] REG_CYCLE_CODE = 8'h0C;
  localparam logic [7:0] REG_TARGET1 = 8'h5A;
  localparam logic [7:0] REG_TARGET2 = 8'h5B;
  localparam logic [7:0] REG_TGT_HYST = 8'h64;
  localparam logic [7:0] REG_THRESH1 = 8'h70;
  localparam logic [7:0] REG_THRESH2 = 8'h71;
  localparam logic [7:0] REG_LOW1 = 8'h72;
  localparam logic [7:0] REG_LOW2 = 8'h73;
  localparam logic [7:0] REG_HIGH1 = 8'h74;
  localparam logic [7:0] REG_HIGH2 = 8'h75;
  localparam logic [7:0] REG_CRIT1 = 8'h76;
  localparam logic [7:0] REG_CRIT2 = 8'h77;
  localparam logic [7:0] REG_RANGE = 8'h78;
  localparam logic [7:0] REG_MINDUTY1 = 8'h79;
  localparam logic [7:0] REG_MINDUTY2 = 8'h7A;
  localparam logic [7:0] REG_CTRL = 8'h7B;
  localparam logic [7:0] REG_STATUS = 8'h7C;
  localparam logic [7:0] REG_TEMP1 = 8'h7D;
  localparam logic [7:0] REG_TEMP2 = 8'h7E;

  // field positions
  localparam int CODE1_LSB = 0;
  localparam int CODE2_LSB = 3;
  localparam int HYST_LSB = 4;
  localparam int ST_LOW1 = 0;
  localparam int ST_HIGH1 = 1;
  localparam int ST_LOW2 = 2;
  localparam int ST_HIGH2 = 3;

  // reset values
  localparam logic [7:0] RST_TARGET = 8'hA4;
  localparam logic [7:0] RST_TGT_HYST = 8'h40;
  localparam logic [7:0] RST_CYCLE_CODE = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h9A;
  localparam logic [7:0] RST_LOW = 8'h40;
  localparam logic [7:0] RST_HIGH = 8'hBF;
  localparam logic [7:0] RST_CRIT = 8'hA4;
  localparam logic [7:0] RST_RANGE = 8'h00;
  localparam logic [7:0] RST_MINDUTY = 8'h40;
  localparam logic [7:0] RST_CTRL = 8'h00;

  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [2:0] SHORT_BASE_LOG2 = 3'h3;

  // monitoring cycle timing
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint MON_CYCLE_NS = 125000000;
  localparam int MON_CYCLE_CLKS = int'(MON_CYCLE_NS / CLK_PERIOD_NS);

endpackage : dftl_pkg

/* File: hw/dftl_zone_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dftl_zone_if;
  logic tick;
  logic enable;
  logic [7:0] temp;
  logic [7:0] target;
  logic [3:0] hyst;
  logic [7:0] low_lim;
  logic [7:0] high_lim;
  logic [2:0] cycle_code;
  logic sw_wr;
  logic [7:0] sw_data;
  logic [7:0] thresh;

  modport ctrl (
    output tick, enable, temp, target, hyst, low_lim, high_lim, cycle_code, sw_wr, sw_data,
    input thresh
  );
  modport zone (
    input tick, enable, temp, target, hyst, low_lim, high_lim, cycle_code, sw_wr, sw_data,
    output thresh
  );
endinterface : dftl_zone_if
`default_nettype wire

/* File: hw/dftl_mon_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module dftl_mon_tick #(
  parameter int CYCLES = dftl_pkg::MON_CYCLE_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  output logic tick_o
);
  logic [31:0] cnt_r;
  wire cnt_last = (cnt_r == 32'(CYCLES - 1));

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 32'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_last ? 32'h0 : cnt_r + 32'h1;
      tick_o <= cnt_last;
    end
  end
endmodule : dftl_mon_tick
`default_nettype wire

/* File: hw/dftl_zone_loop.sv */
`timescale 1ns/10ps
`default_nettype none
module dftl_zone_loop (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  dftl_zone_if.zone zif
);
  logic [10:0] cnt_r;
  logic [7:0] prev_r;
  logic [7:0] thresh_r;
  logic [7:0] thresh_nxt;

  wire [10:0] cnt_nxt = cnt_r + 11'h1;
  // shift amount kept four bits wide so codes above four do not wrap back to short periods
  wire [3:0] short_log2 = {1'b0, zif.cycle_code} + {1'b0, dftl_pkg::SHORT_BASE_LOG2};
  wire [10:0] short_len = 11'h1 << short_log2;
  wire short_hit = ((cnt_nxt & (short_len - 11'h1)) == 11'h0);
  wire long_hit = ((cnt_nxt & ((short_len << 1) - 11'h1)) == 11'h0);
  // operating point minus hysteresis, held at zero rather than wrapping
  wire [7:0] tgt_lo = (zif.target > 8'(zif.hyst)) ? zif.target - 8'(zif.hyst) : 8'h00;
  wire rising = zif.temp > prev_r;
  wire [9:0] short_dec = (short_hit && zif.temp > tgt_lo && rising) ? {1'b0, zif.temp - prev_r, 1'b0} : 10'h0;
  wire [9:0] long_dec = (long_hit && zif.temp > zif.target) ? 10'h1 : 10'h0;
  wire [9:0] dec = short_dec + long_dec;
  wire inc = long_hit && zif.temp < zif.low_lim && thresh_r < zif.high_lim
             && thresh_r < zif.target && zif.temp > thresh_r;

  always_comb
  begin
    thresh_nxt = thresh_r;
    if (zif.sw_wr)
      thresh_nxt = zif.sw_data;
    else if (zif.tick && zif.enable)
    begin
      if (dec != 10'h0)
        thresh_nxt = (dec >= {2'b00, thresh_r}) ? 8'h00 : 8'({2'b00, thresh_r} - dec);
      else if (inc)
        thresh_nxt = thresh_r + 8'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 11'h0;
      prev_r <= 8'h00;
      thresh_r <= dftl_pkg::RST_THRESH;
    end
    else
    begin
      thresh_r <= thresh_nxt;
      if (zif.tick)
      begin
        prev_r <= zif.temp;
        cnt_r <= zif.enable ? cnt_nxt : 11'h0;
      end
    end
  end

  assign zif.thresh = thresh_r;
endmodule : dftl_zone_loop
`default_nettype wire

/* File: hw/dftl_top.sv */
// How it works
// - flag zone temperature below low limit
// - flag zone temperature above high limit
// - fan on once temperature reaches threshold
// - steer zone to target via threshold only
// - full duty above critical limit
// - range setting gives duty slope above threshold
// - raise threshold when zone runs too cool
// - lower threshold when target is exceeded
// - separate target and loop per remote zone
// - targets are 8-bit, one degree steps
// - zone 1 target at 0x5A, reset 0xA4
// - zone 2 target at 0x5B, reset 0xA4
// - target hysteresis bits 7:4 at 0x64
// - reduce threshold above target minus hysteresis
// - short every n, long every 2n cycles
// - zone 1 cycle code bits 2:0 at 0x0C
// - short cycle lowers two per degree rise
// - long cycle lowers one above target
`timescale 1ns/10ps
`default_nettype none
module dftl_top #(
  parameter int MON_CYCLES = dftl_pkg::MON_CYCLE_CLKS,
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] remote1_temp_i,
  input wire logic [7:0] remote2_temp_i,
  output logic [1:0] fan_on_o,
  output logic [7:0] pwm_duty1_o,
  output logic [7:0] pwm_duty2_o,
  output logic [3:0] limit_flags_o
);

  ////////////////////////////////////////////////////////////////////////////
  // duty cycle law shared by both zones

  function automatic logic [7:0] duty_calc(
    input logic [7:0] temp,
    input logic [7:0] thresh,
    input logic [7:0] crit,
    input logic [2:0] range_sh,
    input logic [7:0] min_duty
  );
    logic [15:0] ramp;
    ramp = 16'h0;
    if (temp > crit)
      return dftl_pkg::DUTY_FULL;
    if (temp < thresh)
      return 8'h00;
    ramp = 16'(min_duty) + (16'(temp - thresh) << range_sh);
    return (ramp > 16'(dftl_pkg::DUTY_FULL)) ? dftl_pkg::DUTY_FULL : ramp[7:0];
  endfunction : duty_calc

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire [7:0] idx = paddr_i[9:2];
  wire setup = psel_i && !penable_i;
  wire wr_go = psel_i && penable_i && pready_o && pwrite_i;
  wire [7:0] wb = pwdata_i[7:0];
  wire hit_code = (idx == dftl_pkg::REG_CYCLE_CODE);
  wire hit_tgt1 = (idx == dftl_pkg::REG_TARGET1);
  wire hit_tgt2 = (idx == dftl_pkg::REG_TARGET2);
  wire hit_hyst = (idx == dftl_pkg::REG_TGT_HYST);
  wire hit_th1 = (idx == dftl_pkg::REG_THRESH1);
  wire hit_th2 = (idx == dftl_pkg::REG_THRESH2);
  wire hit_low1 = (idx == dftl_pkg::REG_LOW1);
  wire hit_low2 = (idx == dftl_pkg::REG_LOW2);
  wire hit_high1 = (idx == dftl_pkg::REG_HIGH1);
  wire hit_high2 = (idx == dftl_pkg::REG_HIGH2);
  wire hit_crit1 = (idx == dftl_pkg::REG_CRIT1);
  wire hit_crit2 = (idx == dftl_pkg::REG_CRIT2);
  wire hit_range = (idx == dftl_pkg::REG_RANGE);
  wire hit_md1 = (idx == dftl_pkg::REG_MINDUTY1);
  wire hit_md2 = (idx == dftl_pkg::REG_MINDUTY2);
  wire hit_ctrl = (idx == dftl_pkg::REG_CTRL);
  wire hit_stat = (idx == dftl_pkg::REG_STATUS);
  wire hit_t1 = (idx == dftl_pkg::REG_TEMP1);
  wire hit_t2 = (idx == dftl_pkg::REG_TEMP2);
  // upper address bits outside the map also count as unmapped
  wire upper_zero = (paddr_i[ADDR_W-1:10] == '0);
  wire mapped = upper_zero && (hit_code || hit_tgt1 || hit_tgt2 || hit_hyst || hit_th1 || hit_th2
                || hit_low1 || hit_low2 || hit_high1 || hit_high2 || hit_crit1 || hit_crit2
                || hit_range || hit_md1 || hit_md2 || hit_ctrl || hit_stat || hit_t1 || hit_t2);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] tgt1_r;
  logic [7:0] tgt2_r;
  logic [3:0] hyst_r;
  logic [5:0] code_r;
  logic [7:0] low1_r;
  logic [7:0] low2_r;
  logic [7:0] high1_r;
  logic [7:0] high2_r;
  logic [7:0] crit1_r;
  logic [7:0] crit2_r;
  logic [5:0] range_r;
  logic [7:0] md1_r;
  logic [7:0] md2_r;
  logic [1:0] ctrl_r;
  logic [3:0] stat_r;
  logic [3:0] stat_nxt;
  logic tick;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tgt1_r <= dftl_pkg::RST_TARGET;
      tgt2_r <= dftl_pkg::RST_TARGET;
      hyst_r <= dftl_pkg::RST_TGT_HYST[7:4];
      code_r <= dftl_pkg::RST_CYCLE_CODE[5:0];
      low1_r <= dftl_pkg::RST_LOW;
      low2_r <= dftl_pkg::RST_LOW;
      high1_r <= dftl_pkg::RST_HIGH;
      high2_r <= dftl_pkg::RST_HIGH;
      crit1_r <= dftl_pkg::RST_CRIT;
      crit2_r <= dftl_pkg::RST_CRIT;
      range_r <= dftl_pkg::RST_RANGE[5:0];
      md1_r <= dftl_pkg::RST_MINDUTY;
      md2_r <= dftl_pkg::RST_MINDUTY;
      ctrl_r <= dftl_pkg::RST_CTRL[1:0];
    end
    else if (wr_go)
    begin
      if (hit_tgt1) tgt1_r <= wb;
      if (hit_tgt2) tgt2_r <= wb;
      if (hit_hyst) hyst_r <= wb[dftl_pkg::HYST_LSB +: 4];
      if (hit_code) code_r <= wb[5:0];
      if (hit_low1) low1_r <= wb;
      if (hit_low2) low2_r <= wb;
      if (hit_high1) high1_r <= wb;
      if (hit_high2) high2_r <= wb;
      if (hit_crit1) crit1_r <= wb;
      if (hit_crit2) crit2_r <= wb;
      if (hit_range) range_r <= wb[5:0];
      if (hit_md1) md1_r <= wb;
      if (hit_md2) md2_r <= wb;
      if (hit_ctrl) ctrl_r <= wb[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit flags: set on a monitoring tick, cleared by writing one; set wins

  wire [3:0] stat_set = tick ? {remote2_temp_i > high2_r, remote2_temp_i < low2_r,
                                remote1_temp_i > high1_r, remote1_temp_i < low1_r} : 4'h0;
  wire [3:0] stat_clr = (wr_go && hit_stat) ? pwdata_i[3:0] : 4'h0;

  always_comb
  begin
    stat_nxt = (stat_r & ~stat_clr) | stat_set;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      stat_r <= 4'h0;
    else
      stat_r <= stat_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitoring cycle and the two adaptive zones

  dftl_mon_tick #(
    .CYCLES(MON_CYCLES)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );

  dftl_zone_if z1 ();
  dftl_zone_if z2 ();

  assign z1.tick = tick;
  assign z1.enable = ctrl_r[0];
  assign z1.temp = remote1_temp_i;
  assign z1.target = tgt1_r;
  assign z1.hyst = hyst_r;
  assign z1.low_lim = low1_r;
  assign z1.high_lim = high1_r;
  assign z1.cycle_code = code_r[dftl_pkg::CODE1_LSB +: 3];
  assign z1.sw_wr = wr_go && hit_th1;
  assign z1.sw_data = wb;

  assign z2.tick = tick;
  assign z2.enable = ctrl_r[1];
  assign z2.temp = remote2_temp_i;
  assign z2.target = tgt2_r;
  assign z2.hyst = hyst_r;
  assign z2.low_lim = low2_r;
  assign z2.high_lim = high2_r;
  assign z2.cycle_code = code_r[dftl_pkg::CODE2_LSB +: 3];
  assign z2.sw_wr = wr_go && hit_th2;
  assign z2.sw_data = wb;

  // one loop instance per zone keeps the two zones independent
  dftl_zone_loop u_zone1 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .zif(z1)
  );

  dftl_zone_loop u_zone2 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .zif(z2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fan drive

  wire [7:0] duty1 = duty_calc(remote1_temp_i, z1.thresh, crit1_r, range_r[2:0], md1_r);
  wire [7:0] duty2 = duty_calc(remote2_temp_i, z2.thresh, crit2_r, range_r[5:3], md2_r);
  wire [1:0] fan_on = {remote2_temp_i >= z2.thresh || remote2_temp_i > crit2_r,
                       remote1_temp_i >= z1.thresh || remote1_temp_i > crit1_r};

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fan_on_o <= 2'b00;
      pwm_duty1_o <= 8'h00;
      pwm_duty2_o <= 8'h00;
      limit_flags_o <= 4'h0;
    end
    else
    begin
      fan_on_o <= fan_on;
      pwm_duty1_o <= duty1;
      pwm_duty2_o <= duty2;
      limit_flags_o <= stat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, answered one cycle after setup

  logic [7:0] rd_val;

  always_comb
  begin
    rd_val = 8'h00;
    if (hit_code) rd_val = {2'b00, code_r};
    if (hit_tgt1) rd_val = tgt1_r;
    if (hit_tgt2) rd_val = tgt2_r;
    if (hit_hyst) rd_val = {hyst_r, 4'h0};
    if (hit_th1) rd_val = z1.thresh;
    if (hit_th2) rd_val = z2.thresh;
    if (hit_low1) rd_val = low1_r;
    if (hit_low2) rd_val = low2_r;
    if (hit_high1) rd_val = high1_r;
    if (hit_high2) rd_val = high2_r;
    if (hit_crit1) rd_val = crit1_r;
    if (hit_crit2) rd_val = crit2_r;
    if (hit_range) rd_val = {2'b00, range_r};
    if (hit_md1) rd_val = md1_r;
    if (hit_md2) rd_val = md2_r;
    if (hit_ctrl) rd_val = {6'h00, ctrl_r};
    if (hit_stat) rd_val = {4'h0, stat_r};
    if (hit_t1) rd_val = remote1_temp_i;
    if (hit_t2) rd_val = remote2_temp_i;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= setup;
      pslverr_o <= setup && !mapped;
      if (setup)
        prdata_o <= (mapped && !pwrite_i) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

endmodule : dftl_top
`default_nettype wire

/* File: testbench/dftl_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module dftl_top_properties (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] fan_on_o,
  input wire logic [7:0] pwm_duty1_o,
  input wire logic [7:0] pwm_duty2_o,
  input wire logic [3:0] limit_flags_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire logic wr_acc = psel_i && penable_i && pwrite_i;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence
  property p_setup_answer;
    s_setup |=> s_access;
  endproperty
  property p_ready_cause;
    $rose(pready_o) |-> $past(psel_i && !penable_i);
  endproperty
  property p_err_with_ready;
    pslverr_o |-> pready_o && penable_i;
  endproperty
  property p_rdata_width;
    prdata_o[31:8] == 24'h000000;
  endproperty
  property p_rdata_hold;
    pready_o && !pwrite_i |=> $stable(prdata_o);
  endproperty
  property p_err_read_zero;
    pslverr_o && !pwrite_i |-> prdata_o == 32'h00000000;
  endproperty
  // flags only clear through a software write, never by themselves
  property p_low1_sticky;
    limit_flags_o[0] && !wr_acc |=> limit_flags_o[0];
  endproperty
  property p_high2_sticky;
    limit_flags_o[3] && !wr_acc |=> limit_flags_o[3];
  endproperty
  property p_duty1_fan;
    pwm_duty1_o != 8'h00 |-> fan_on_o[0];
  endproperty
  property p_duty2_fan;
    pwm_duty2_o != 8'h00 |-> fan_on_o[1];
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_setup_answer: assert property (p_setup_answer)
    else $error("no ready in the cycle after setup");
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without a preceding setup");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error response outside an access");
  a_rdata_width: assert property (p_rdata_width)
    else $error("read data above bit 7 not zero");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved after the access");
  a_err_read_zero: assert property (p_err_read_zero)
    else $error("refused read returned data");
  a_low1_sticky: assert property (p_low1_sticky)
    else $error("zone 1 low flag dropped on its own");
  a_high2_sticky: assert property (p_high2_sticky)
    else $error("zone 2 high flag dropped on its own");
  a_duty1_fan: assert property (p_duty1_fan)
    else $error("zone 1 duty without fan on");
  a_duty2_fan: assert property (p_duty2_fan)
    else $error("zone 2 duty without fan on");
endmodule : dftl_top_properties
bind dftl_top dftl_top_properties u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .fan_on_o(fan_on_o), .pwm_duty1_o(pwm_duty1_o), .pwm_duty2_o(pwm_duty2_o), .limit_flags_o(limit_flags_o));
`default_nettype wire

/* File: testbench/dftl_apb_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dftl_apb_host (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h00000000;
  end
  // no wait limit here on purpose: only the bench timeout may end a stalled access
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= we;
    paddr_o <= {2'b00, idx, 2'b00};
    pwdata_o <= {24'h000000, wd};
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1)
      @(posedge clk_i);
    rd = prdata_i[7:0];
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released data lines toggle so a stale value is never mistaken for a fresh one
    pwdata_o <= ~pwdata_o;
  endtask : xfer
endmodule : dftl_apb_host
`default_nettype wire

/* File: testbench/dftl_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dftl_top_tb_top;
  localparam int MON = 20;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, errv, ramp_en = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] t1 = 8'h80, t2 = 8'h80, d1, d2, rdv;
  logic [1:0] fan;
  logic [3:0] flags;
  int cmp_count = 0, miscompares = 0, cycles = 0, ramp_cnt = 0;
  logic [7:0] rst_idx [4] = '{dftl_pkg::REG_TARGET1, dftl_pkg::REG_TARGET2, dftl_pkg::REG_TGT_HYST,
                              dftl_pkg::REG_CYCLE_CODE};
  logic [7:0] rst_val [4] = '{8'hA4, 8'hA4, 8'h40, 8'h00};
  always #50 ref_clk_i = ~ref_clk_i;
  dftl_apb_host host (.clk_i(ref_clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  dftl_top #(.MON_CYCLES(MON), .ADDR_W(12)) uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .remote1_temp_i(t1), .remote2_temp_i(t2), .fan_on_o(fan),
    .pwm_duty1_o(d1), .pwm_duty2_o(d2), .limit_flags_o(flags));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    host.xfer(1'b1, idx, d, r, e);
    chk("write response", 8'h00, {7'h00, e});
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    host.xfer(1'b0, idx, 8'h00, r, e);
    chk(nm, exp, r);
  endtask : rdc
  task automatic settle(input logic [7:0] a, input logic [7:0] b, input int n);
    @(posedge ref_clk_i);
    t1 <= a;
    t2 <= b;
    repeat (n) @(posedge ref_clk_i);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  // zone 2 temperature climbs one degree per monitoring period, so every tick sees a rise of one
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (ramp_en)
    begin
      ramp_cnt <= (ramp_cnt == MON - 1) ? 0 : ramp_cnt + 1;
      if (ramp_cnt == MON - 1)
        t2 <= t2 + 8'h01;
    end
    if (cycles == 4000)
    begin
      miscompares++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++)
      rdc("reset value", rst_idx[i], rst_val[i]);
    $display("test reset_values done");
    wr(dftl_pkg::REG_TARGET1, 8'h3C);
    wr(dftl_pkg::REG_TARGET2, 8'hC3);
    rdc("target1", dftl_pkg::REG_TARGET1, 8'h3C);
    rdc("target2", dftl_pkg::REG_TARGET2, 8'hC3);
    wr(dftl_pkg::REG_TGT_HYST, 8'hFF);
    rdc("hysteresis", dftl_pkg::REG_TGT_HYST, 8'hF0);
    host.xfer(1'b0, 8'h01, 8'h00, rdv, errv);
    chk("unmapped response", 8'h01, {7'h00, errv});
    chk("unmapped data", 8'h00, rdv);
    $display("test register_access done");
    settle(8'h9A, 8'h80, 3);
    chk("fan at threshold", 8'h01, {6'h00, fan});
    chk("duty at threshold", 8'h40, d1);
    settle(8'h99, 8'h80, 3);
    chk("fan below threshold", 8'h00, {6'h00, fan});
    chk("duty below threshold", 8'h00, d1);
    settle(8'hA5, 8'h80, 3);
    chk("duty above critical", 8'hFF, d1);
    wr(dftl_pkg::REG_RANGE, 8'h01);
    settle(8'h9C, 8'h80, 3);
    chk("duty with slope", 8'h44, d1);
    wr(dftl_pkg::REG_RANGE, 8'h00);
    $display("test fan_drive done");
    settle(8'h80, 8'hC5, MON + 5);
    chk("high flag output", 8'h08, {4'h0, flags});
    chk("fan zone 2 only", 8'h02, {6'h00, fan});
    chk("duty2 above critical", 8'hFF, d2);
    rdc("status high", dftl_pkg::REG_STATUS, 8'h08);
    settle(8'h80, 8'h80, 1);
    wr(dftl_pkg::REG_STATUS, 8'h0F);
    rdc("status cleared", dftl_pkg::REG_STATUS, 8'h00);
    $display("test limit_flags done");
    wr(dftl_pkg::REG_TARGET1, 8'h60);
    wr(dftl_pkg::REG_TARGET2, 8'h70);
    wr(dftl_pkg::REG_TGT_HYST, 8'h40);
    wr(dftl_pkg::REG_LOW1, 8'h58);
    wr(dftl_pkg::REG_THRESH1, 8'h50);
    wr(dftl_pkg::REG_THRESH2, 8'h60);
    settle(8'h55, 8'h6D, 1);
    ramp_en <= 1'b1;
    wr(dftl_pkg::REG_CTRL, 8'h03);
    repeat (10 * MON) @(posedge ref_clk_i);
    rdc("thresh1 before long", dftl_pkg::REG_THRESH1, 8'h50);
    rdc("thresh2 after short", dftl_pkg::REG_THRESH2, 8'h5E);
    chk("low flag output", 8'h01, {7'h00, flags[0]});
    repeat (7 * MON) @(posedge ref_clk_i);
    rdc("thresh1 after long", dftl_pkg::REG_THRESH1, 8'h51);
    rdc("thresh2 after long", dftl_pkg::REG_THRESH2, 8'h5B);
    $display("test adaptive_loop done");
    // a disabled tick clears the zone counter before the slower code is enabled
    wr(dftl_pkg::REG_CTRL, 8'h00);
    repeat (MON + 2) @(posedge ref_clk_i);
    wr(dftl_pkg::REG_CYCLE_CODE, 8'h08);
    rdc("cycle code", dftl_pkg::REG_CYCLE_CODE, 8'h08);
    wr(dftl_pkg::REG_CTRL, 8'h02);
    repeat (10 * MON) @(posedge ref_clk_i);
    rdc("thresh2 code one early", dftl_pkg::REG_THRESH2, 8'h5B);
    repeat (8 * MON) @(posedge ref_clk_i);
    rdc("thresh2 code one short", dftl_pkg::REG_THRESH2, 8'h59);
    $display("test cycle_code done");
    close_out();
  end
endmodule : dftl_top_tb_top
`default_nettype wire
